// ==== design/sfcfe_defines.vh ====
`ifndef SFCFE_DEFINES_VH
`define SFCFE_DEFINES_VH
`define SFCFE_OP_READ      8'h03
`define SFCFE_OP_HS_READ   8'h0b
`define SFCFE_OP_DUAL_OUT  8'h3b
`define SFCFE_OP_DUAL_IO   8'hbb
`define SFCFE_OP_SECT_A    8'h20
`define SFCFE_OP_SECT_B    8'hd7
`define SFCFE_OP_BLOCK     8'hd8
`define SFCFE_OP_CHIP_A    8'h60
`define SFCFE_OP_CHIP_B    8'hc7
`define SFCFE_OP_PROG      8'h02
`define SFCFE_OP_SR_READ   8'h05
`define SFCFE_OP_SR_WRITE  8'h01
`define SFCFE_OP_WRITE_ENABLE_CMD      8'h06
`define SFCFE_OP_WRITE_DISABLE_CMD      8'h04
`define SFCFE_OP_ID_READ   8'hab
`define SFCFE_OP_SLEEP     8'hb9
`define SFCFE_OP_JEDEC     8'h9f
`define SFCFE_SR_BUSY      0
`define SFCFE_SR_WEL       1
`define SFCFE_SR_LOCK      7
`define SFCFE_SR_RESET     8'h00
`define SFCFE_SR_WMASK     8'hbc
`define SFCFE_DEV_ID       8'h5a
`define SFCFE_JEDEC_ID     32'ha1b2c3d4
`define SFCFE_PAGE_BYTES   9'h100
`endif

// ==== design/sfcfe_sync.v ====
`timescale 1ns/1ns
module sfcfe_sync (
  input  wire clk,
  input  wire reset_n,
  input  wire d,
  output wire q
);
  reg s1_reg;
  reg s2_reg;
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s1_reg <= 1'b0;
      s2_reg <= 1'b0;
    end else begin
      s1_reg <= d;
      s2_reg <= s1_reg;
    end
  end
  assign q = s2_reg;
endmodule

// ==== design/sfcfe_top.v ====
// Summary of operation
// - Modes 0 and 3: sample on rising clock, change output after falling.
// - Chip select falling starts a command; high means standby.
// - All transfers are 8-bit cycles, most significant bit first.
// - Erase, program and status write need write-enable first.
// - Chip select rising mid-byte aborts the command.
// - Opcode 03H reads with three address bytes, no dummy.
// - Opcode 0BH reads with three address bytes and one dummy byte.
// - Opcode 3BH reads with dummy, data on both lines.
// - Opcode BBH sends address, dummy and data on both lines.
// - Opcodes 20H and D7H erase a 4 KByte sector by bits 12 up.
// - Opcode D8H erases a 64 KByte block by bits 16 up.
// - Opcodes 60H and C7H erase the whole array.
// - Opcode 02H with address programs 1 to 256 bytes into a page.
// - Opcode 05H repeats the status byte until deselect.
// - Opcode 01H with one data byte writes status.
// - Opcode 06H sets write-enable latch, 04H clears it.
// - Opcode ABH with 24 dummy bits repeats the device identifier.
// - Opcode ABH alone releases deep power-down.
// - Opcode B9H enters deep power-down.
// - Opcode 9FH repeats a four-byte identification sequence.
// - Hold low while selected pauses the serial transfer.
// - Write commands ending off a byte boundary are ignored.
// - Status write with two or more data bytes is ignored.
`timescale 1ns/1ns
`include "sfcfe_defines.vh"
module sfcfe_top (
  input  wire        clk,
  input  wire        reset_n,
  input  wire        spi_sck,
  input  wire        spi_cs_n,
  input  wire        hold_n,
  input  wire        wp_n,
  input  wire        dual_io_lines_in0,
  input  wire        dual_io_lines_in1,
  output reg         dual_io_lines_out0,
  output reg         dual_io_lines_out1,
  output reg         dual_io_lines_oe0_n,
  output reg         dual_io_lines_oe1_n,
  output reg  [8:0]  mem_rd_addr,
  input  wire [7:0]  mem_rd_data,
  output reg         op_start,
  output reg  [1:0]  op_kind,
  output reg  [23:0] op_addr,
  output reg         prog_wr,
  output reg  [7:0]  prog_data,
  output reg  [8:0]  prog_col,
  input  wire        op_done,
  output wire        sleeping,
  output wire [7:0]  status_out
);
  localparam ST_OP    = 3'd0;
  localparam ST_ADDR  = 3'd1;
  localparam ST_DUMMY = 3'd2;
  localparam ST_DOUT  = 3'd3;
  localparam ST_DIN   = 3'd4;
  localparam ST_IDLE  = 3'd5;
  localparam K_SECT   = 2'd0;
  localparam K_BLOCK  = 2'd1;
  localparam K_CHIP   = 2'd2;
  localparam K_PROG   = 2'd3;
  localparam [31:0] JEDEC_WORD = `SFCFE_JEDEC_ID;

  wire sck_s;
  wire cs_s;
  wire hold_s;
  wire wp_s;
  wire di0_s;
  wire di1_s;

  sfcfe_sync u_s0 (.clk(clk), .reset_n(reset_n), .d(spi_sck), .q(sck_s));
  sfcfe_sync u_s1 (.clk(clk), .reset_n(reset_n), .d(spi_cs_n), .q(cs_s));
  sfcfe_sync u_s2 (.clk(clk), .reset_n(reset_n), .d(hold_n), .q(hold_s));
  sfcfe_sync u_s3 (.clk(clk), .reset_n(reset_n), .d(wp_n), .q(wp_s));
  sfcfe_sync u_s4 (.clk(clk), .reset_n(reset_n),
                   .d(dual_io_lines_in0), .q(di0_s));
  sfcfe_sync u_s5 (.clk(clk), .reset_n(reset_n),
                   .d(dual_io_lines_in1), .q(di1_s));

  reg        sck_d_reg;
  reg        cs_d_reg;
  reg [2:0]  state_reg;
  reg [7:0]  opc_reg;
  reg [7:0]  sh_reg;
  reg [2:0]  bit_reg;
  reg [1:0]  abyte_reg;
  reg [23:0] addr_reg;
  reg [7:0]  out_reg;
  reg [1:0]  ocnt_reg;
  reg        dual_reg;
  reg [8:0]  nbytes_reg;
  reg        sleep_reg;
  reg        wel_reg;
  reg        busy_reg;
  reg [7:0]  sr_reg;
  reg [7:0]  sr_new_reg;
  reg        started_reg;
  reg        load_reg;

  // Hold freezes clock edge detection, so no bit moves while paused.
  // hold pauses
  wire active = !cs_s && hold_s;
  wire rise   = active && sck_s && !sck_d_reg;
  wire fall   = active && !sck_s && sck_d_reg;
  wire cs_rise = cs_s && !cs_d_reg;
  wire cs_fall = !cs_s && cs_d_reg;
  wire dual_in = dual_reg && (state_reg == ST_ADDR ||
                              state_reg == ST_DUMMY);
  wire [7:0] sh_next = dual_in ? {sh_reg[5:0], di1_s, di0_s}
                               : {sh_reg[6:0], di0_s};
  wire byte_done = dual_in ? (bit_reg == 3'd3) : (bit_reg == 3'd7);
  wire [7:0] status_now = {sr_reg[7:2], wel_reg, busy_reg};

  assign sleeping   = sleep_reg;
  assign status_out = status_now;

  function is_write_op;
    input [7:0] op;
    begin
      is_write_op = op == `SFCFE_OP_SECT_A || op == `SFCFE_OP_SECT_B ||
                    op == `SFCFE_OP_BLOCK  || op == `SFCFE_OP_CHIP_A ||
                    op == `SFCFE_OP_CHIP_B || op == `SFCFE_OP_PROG   ||
                    op == `SFCFE_OP_SR_WRITE;
    end
  endfunction

  function [7:0] first_out;
    input [7:0]  op;
    input [23:0] a;
    input [7:0]  md;
    input [7:0]  st;
    reg   [31:0] jw;
    begin
      // Identification bytes leave most significant byte first.
      jw = JEDEC_WORD >> {~a[1:0], 3'd0};
      case (op)
        `SFCFE_OP_SR_READ: first_out = st;
        `SFCFE_OP_ID_READ: first_out = `SFCFE_DEV_ID;
        `SFCFE_OP_JEDEC:   first_out = jw[7:0];
        default:           first_out = md;
      endcase
    end
  endfunction

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sck_d_reg <= 1'b0;
      cs_d_reg <= 1'b1;
      state_reg <= ST_IDLE;
      opc_reg <= 8'h00;
      sh_reg <= 8'h00;
      bit_reg <= 3'd0;
      abyte_reg <= 2'd0;
      addr_reg <= 24'h000000;
      out_reg <= 8'h00;
      ocnt_reg <= 2'd0;
      dual_reg <= 1'b0;
      nbytes_reg <= 9'h000;
      sleep_reg <= 1'b0;
      wel_reg <= 1'b0;
      busy_reg <= 1'b0;
      sr_reg <= `SFCFE_SR_RESET;
      sr_new_reg <= 8'h00;
      started_reg <= 1'b0;
      load_reg <= 1'b0;
      op_start <= 1'b0;
      op_kind <= K_SECT;
      op_addr <= 24'h000000;
      prog_wr <= 1'b0;
      prog_data <= 8'h00;
      prog_col <= 9'h000;
      mem_rd_addr <= 9'h000;
      dual_io_lines_out0 <= 1'b0;
      dual_io_lines_out1 <= 1'b0;
      dual_io_lines_oe0_n <= 1'b1;
      dual_io_lines_oe1_n <= 1'b1;
    end else begin
      sck_d_reg <= sck_s;
      cs_d_reg <= cs_s;
      op_start <= 1'b0;
      prog_wr <= 1'b0;
      // The array answers one cycle after the address, so load here.
      if (load_reg) begin
        load_reg <= 1'b0;
        out_reg <= mem_rd_data;
        mem_rd_addr <= {1'b0, mem_rd_addr[7:0] + 8'h01};
      end
      if (busy_reg && op_done) begin
        busy_reg <= 1'b0;
        wel_reg <= 1'b0;
        if (opc_reg == `SFCFE_OP_SR_WRITE)
          sr_reg <= (sr_reg & ~`SFCFE_SR_WMASK) |
                    (sr_new_reg & `SFCFE_SR_WMASK);
      end
      if (cs_fall) begin
        state_reg <= ST_OP;
        bit_reg <= 3'd0;
        abyte_reg <= 2'd0;
        dual_reg <= 1'b0;
        nbytes_reg <= 9'h000;
        started_reg <= 1'b0;
      end
      if (cs_rise) begin
        state_reg <= ST_IDLE;
        dual_io_lines_oe0_n <= 1'b1;
        dual_io_lines_oe1_n <= 1'b1;
        if (bit_reg == 3'd0 && state_reg != ST_IDLE && !busy_reg &&
            !started_reg) begin
          if (state_reg == ST_DIN && opc_reg == `SFCFE_OP_SLEEP)
            sleep_reg <= 1'b1;
          if (state_reg == ST_ADDR && abyte_reg == 2'd0 &&
              opc_reg == `SFCFE_OP_ID_READ)
            sleep_reg <= 1'b0;
          if (state_reg == ST_DIN && opc_reg == `SFCFE_OP_WRITE_ENABLE_CMD)
            wel_reg <= 1'b1;
          if (state_reg == ST_DIN && opc_reg == `SFCFE_OP_WRITE_DISABLE_CMD)
            wel_reg <= 1'b0;
          if (wel_reg && is_write_op(opc_reg)) begin
            if (state_reg == ST_DIN && nbytes_reg == 9'h000 &&
                abyte_reg == 2'd3 &&
                opc_reg != `SFCFE_OP_PROG) begin
              busy_reg <= 1'b1;
              op_start <= 1'b1;
              op_kind <= (opc_reg == `SFCFE_OP_BLOCK) ? K_BLOCK : K_SECT;
              op_addr <= (opc_reg == `SFCFE_OP_BLOCK) ?
                         {addr_reg[23:16], 16'h0000} :
                         {addr_reg[23:12], 12'h000};
            end
            if (state_reg == ST_DIN && abyte_reg == 2'd0 &&
                (opc_reg == `SFCFE_OP_CHIP_A ||
                 opc_reg == `SFCFE_OP_CHIP_B)) begin
              busy_reg <= 1'b1;
              op_start <= 1'b1;
              op_kind <= K_CHIP;
            end
            if (opc_reg == `SFCFE_OP_PROG && state_reg == ST_DIN &&
                nbytes_reg != 9'h000 && abyte_reg == 2'd3) begin
              busy_reg <= 1'b1;
              op_start <= 1'b1;
              op_kind <= K_PROG;
              op_addr <= addr_reg;
            end
            if (opc_reg == `SFCFE_OP_SR_WRITE && nbytes_reg == 9'h001 &&
                !(!wp_s && sr_reg[`SFCFE_SR_LOCK]))
              busy_reg <= 1'b1;
          end
        end
      end else if (rise && state_reg != ST_IDLE &&
                   state_reg != ST_DOUT) begin
        sh_reg <= sh_next;
        bit_reg <= byte_done ? 3'd0 : bit_reg + 3'd1;
        if (byte_done) begin
          case (state_reg)
            ST_OP: begin
              opc_reg <= sh_next;
              dual_reg <= (sh_next == `SFCFE_OP_DUAL_IO);
              if (sleep_reg && sh_next != `SFCFE_OP_ID_READ)
                state_reg <= ST_IDLE;
              else if (busy_reg && sh_next != `SFCFE_OP_SR_READ)
                state_reg <= ST_IDLE;
              else
                case (sh_next)
                  `SFCFE_OP_READ, `SFCFE_OP_HS_READ, `SFCFE_OP_DUAL_OUT,
                  `SFCFE_OP_DUAL_IO, `SFCFE_OP_SECT_A, `SFCFE_OP_SECT_B,
                  `SFCFE_OP_BLOCK, `SFCFE_OP_PROG, `SFCFE_OP_ID_READ:
                    state_reg <= ST_ADDR;
                  `SFCFE_OP_SR_READ, `SFCFE_OP_JEDEC: begin
                    state_reg <= ST_DOUT;
                    addr_reg <= 24'h000000;
                    out_reg <= (sh_next == `SFCFE_OP_SR_READ) ?
                               status_now : JEDEC_WORD[31:24];
                    ocnt_reg <= 2'd0;
                  end
                  default:
                    state_reg <= ST_DIN;
                endcase
            end
            ST_ADDR: begin
              addr_reg <= {addr_reg[15:0], sh_next};
              abyte_reg <= abyte_reg + 2'd1;
              mem_rd_addr <= {1'b0, addr_reg[7:0]};
              if (abyte_reg == 2'd2) begin
                mem_rd_addr <= {1'b0, sh_next};
                case (opc_reg)
                  `SFCFE_OP_READ, `SFCFE_OP_ID_READ: begin
                    state_reg <= ST_DOUT;
                    out_reg <= `SFCFE_DEV_ID;
                    load_reg <= (opc_reg == `SFCFE_OP_READ);
                    ocnt_reg <= 2'd1;
                  end
                  `SFCFE_OP_HS_READ, `SFCFE_OP_DUAL_OUT, `SFCFE_OP_DUAL_IO:
                    state_reg <= ST_DUMMY;
                  default:
                    state_reg <= ST_DIN;
                endcase
              end
            end
            ST_DUMMY: begin
              state_reg <= ST_DOUT;
              dual_reg <= (opc_reg != `SFCFE_OP_HS_READ);
              out_reg <= mem_rd_data;
              mem_rd_addr <= {1'b0, addr_reg[7:0] + 8'h01};
              ocnt_reg <= 2'd1;
            end
            ST_DIN: begin
              if (nbytes_reg != 9'h1ff)
                nbytes_reg <= nbytes_reg + 9'h001;
              sr_new_reg <= sh_next;
              if (opc_reg == `SFCFE_OP_PROG &&
                  nbytes_reg < `SFCFE_PAGE_BYTES) begin
                prog_wr <= 1'b1;
                prog_data <= sh_next;
                prog_col <= {1'b0, addr_reg[7:0] + nbytes_reg[7:0]};
              end
            end
            default: state_reg <= ST_IDLE;
          endcase
        end
      end else if (fall && state_reg == ST_DOUT) begin
        dual_io_lines_oe1_n <= 1'b0;
        dual_io_lines_oe0_n <= !dual_reg;
        if (dual_reg) begin
          dual_io_lines_out1 <= out_reg[7];
          dual_io_lines_out0 <= out_reg[6];
          out_reg <= {out_reg[5:0], 2'b00};
        end else begin
          dual_io_lines_out1 <= out_reg[7];
          out_reg <= {out_reg[6:0], 1'b0};
        end
        if ((dual_reg && bit_reg == 3'd3) || bit_reg == 3'd7) begin
          bit_reg <= 3'd0;
          addr_reg <= addr_reg + 24'h000001;
          // The array already shows the next byte; look one further ahead.
          mem_rd_addr <= {1'b0, addr_reg[7:0] + 8'h02};
          out_reg <= first_out(opc_reg, addr_reg + 24'h000001,
                               mem_rd_data, status_now);
        end else begin
          bit_reg <= bit_reg + 3'd1;
        end
      end
    end
  end
endmodule

// ==== testbench/sfcfe_checker.sv ====
`timescale 1ns/1ns
module sfcfe_checker (
  input logic       clk,
  input logic       reset_n,
  input logic       spi_sck,
  input logic       spi_cs_n,
  input logic       wp_n,
  input logic       dual_io_lines_out1,
  input logic       dual_io_lines_oe0_n,
  input logic       dual_io_lines_oe1_n,
  input logic       op_start,
  input logic       prog_wr,
  input logic [8:0] prog_col,
  input logic       sleeping,
  input logic [7:0] status_out
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  a_idle_release: assert property (
    spi_cs_n [*6] |-> dual_io_lines_oe1_n && dual_io_lines_oe0_n)
    else $error("pins driven while deselected");
  a_start_desel: assert property (
    op_start |-> spi_cs_n) else $error("start while selected");
  a_start_latch: assert property (
    op_start |-> $past(status_out[1])) else $error("start without latch");
  a_start_idle: assert property (
    op_start |-> !$past(status_out[0])) else $error("start while busy");
  a_start_busy: assert property (
    op_start |=> status_out[0]) else $error("busy not set");
  a_latch_clear: assert property (
    $fell(status_out[0]) |-> !status_out[1]) else $error("latch kept");
  a_sleep_quiet: assert property (
    sleeping |-> dual_io_lines_oe1_n) else $error("drive while asleep");
  a_dual_pair: assert property (
    !dual_io_lines_oe0_n |-> !dual_io_lines_oe1_n)
    else $error("line0 driven alone");
  a_out_on_low: assert property (
    !dual_io_lines_oe1_n && $changed(dual_io_lines_out1) |-> !spi_sck)
    else $error("output changed with clock high");
  a_page_col: assert property (
    prog_wr |-> prog_col < 9'h100) else $error("column past page");
  a_lock_hold: assert property (
    (!wp_n && status_out[7]) [*4] |=> status_out[7])
    else $error("lock bit cleared");
  c_start: cover property (op_start);
  c_prog: cover property (prog_wr);
  c_sleep: cover property ($rose(sleeping));
  c_dual: cover property (!dual_io_lines_oe0_n);
endmodule

bind sfcfe_top sfcfe_checker i_chk (.clk(clk), .reset_n(reset_n),
  .spi_sck(spi_sck), .spi_cs_n(spi_cs_n), .wp_n(wp_n),
  .dual_io_lines_out1(dual_io_lines_out1),
  .dual_io_lines_oe0_n(dual_io_lines_oe0_n),
  .dual_io_lines_oe1_n(dual_io_lines_oe1_n), .op_start(op_start),
  .prog_wr(prog_wr), .prog_col(prog_col), .sleeping(sleeping),
  .status_out(status_out));

// ==== testbench/sfcfe_spi_master.sv ====
`timescale 1ns/1ns
module sfcfe_spi_master (
  input  logic clk,
  input  logic line0,
  input  logic line1,
  output logic sck,
  output logic cs_n,
  output logic mosi,
  output logic mosi_oe
);
  logic cpol = 1'b0;
  initial begin
    sck = 1'b0;
    cs_n = 1'b1;
    mosi = 1'b0;
    mosi_oe = 1'b1;
  end
  task open();
    sck = cpol;
    cs_n = 1'b0;
    mosi_oe = 1'b1;
    repeat (4) @(negedge clk);
  endtask
  // A released data line shows the inverse of its last value.
  task close();
    repeat (4) @(negedge clk);
    cs_n = 1'b1;
    sck = cpol;
    mosi = ~mosi;
    repeat (8) @(negedge clk);
  endtask
  // set after fall, sample on rise
  task xfer(input logic [7:0] d, input int nb, input logic dual,
            output logic [7:0] q);
    q = 8'h00;
    mosi_oe = !dual;
    for (int i = 7; i > 7 - nb; i -= dual ? 2 : 1) begin
      sck = 1'b0;
      mosi = d[i];
      repeat (4) @(negedge clk);
      sck = 1'b1;
      if (dual) q[i-:2] = {line1, line0};
      else q[i] = line1;
      repeat (4) @(negedge clk);
    end
  endtask
endmodule

// ==== testbench/sfcfe_top_tb.sv ====
`timescale 1ns/1ns
`include "sfcfe_defines.vh"
module sfcfe_top_tb;
  localparam logic [7:0]  K = 8'h5c;
  localparam logic [31:0] JID = `SFCFE_JEDEC_ID;
  localparam logic [7:0]  DID = `SFCFE_DEV_ID;
  typedef struct {
    logic [7:0]  op;
    int          na;
    int          nd;
    logic        dual;
    logic        m3;
    logic [23:0] a;
    logic [31:0] exp;
  } sfcfe_row_t;
  logic        clk = 1'b0;
  logic        reset_n = 1'b0;
  logic        hold_n = 1'b1;
  logic        wp_n = 1'b1;
  logic [7:0]  busy_sr = 8'h00;
  logic [1:0]  kind_seen;
  logic [23:0] addr_seen;
  logic [7:0]  pdata_seen, q;
  logic [31:0] r;
  int          err_total = 0, n_tests = 0, n_ops = 0, n_wr = 0, n0;
  wire         sck, cs_n, mosi, mosi_oe, out0, out1, oe0_n, oe1_n;
  wire         op_start, prog_wr, sleeping;
  wire [8:0]   mem_rd_addr, prog_col;
  wire [1:0]   op_kind;
  wire [23:0]  op_addr;
  wire [7:0]   prog_data, status_out;
  // Both lines are pulled up when nobody drives them.
  wire         line0 = !oe0_n ? out0 : (mosi_oe ? mosi : 1'b1);
  wire         line1 = !oe1_n ? out1 : 1'b1;
  wire [7:0]   mem_rd_data = mem_rd_addr[7:0] ^ K;
  wire         op_done = busy_sr[7];
  sfcfe_row_t  rows [7];
  logic [7:0]  eop [5] = '{8'h20, 8'hd7, 8'hd8, 8'h60, 8'hc7};
  logic [1:0]  ekind [5] = '{2'h0, 2'h0, 2'h1, 2'h2, 2'h2};
  logic [23:0] emask [5] = '{24'hfff000, 24'hfff000, 24'hff0000, 0, 0};

  always #10 clk = ~clk;
  // Array work ends eight cycles after busy is seen.
  always @(negedge clk) begin
    busy_sr <= {busy_sr[6:0], status_out[0]};
    if (op_start) begin
      n_ops++;
      kind_seen = op_kind;
      addr_seen = op_addr;
    end
    if (prog_wr) begin
      n_wr++;
      pdata_seen = prog_data;
    end
  end
  sfcfe_spi_master i_mst (.clk(clk), .line0(line0), .line1(line1),
    .sck(sck), .cs_n(cs_n), .mosi(mosi), .mosi_oe(mosi_oe));
  sfcfe_top i_dut (.clk(clk), .reset_n(reset_n), .spi_sck(sck),
    .spi_cs_n(cs_n), .hold_n(hold_n), .wp_n(wp_n),
    .dual_io_lines_in0(line0), .dual_io_lines_in1(line1),
    .dual_io_lines_out0(out0), .dual_io_lines_out1(out1),
    .dual_io_lines_oe0_n(oe0_n), .dual_io_lines_oe1_n(oe1_n),
    .mem_rd_addr(mem_rd_addr), .mem_rd_data(mem_rd_data),
    .op_start(op_start), .op_kind(op_kind), .op_addr(op_addr),
    .prog_wr(prog_wr), .prog_data(prog_data), .prog_col(prog_col),
    .op_done(op_done), .sleeping(sleeping), .status_out(status_out));

  function automatic logic [31:0] m4(input logic [7:0] a);
    m4 = {a ^ K, (a + 8'h1) ^ K, (a + 8'h2) ^ K, (a + 8'h3) ^ K};
  endfunction
  task check(input string what, input logic [31:0] got, exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task results();
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task wait_idle();
    for (int k = 0; k < 400; k++) begin
      if (status_out[0] === 1'b0) return;
      @(negedge clk);
    end
    err_total++;
    results();
  endtask
  task cmd(input logic [7:0] op, input int na, nd, nrd,
           input logic dual, input logic [23:0] a, input logic [7:0] wd);
    r = 32'h0;
    i_mst.open();
    i_mst.xfer(op, 8, 1'b0, q);
    for (int i = 0; i < na + nd; i++)
      i_mst.xfer(i < na ? a[23-8*i-:8] : 8'h00, 8, 1'b0, q);
    for (int i = 0; i < nrd; i++) begin
      i_mst.xfer(wd, 8, dual, q);
      r = {r[23:0], q};
    end
    i_mst.close();
  endtask
  task raw(input logic [47:0] s, input int nb, input int held);
    i_mst.open();
    for (int i = 0; i < 6; i++) begin
      hold_n = (i != held);
      i_mst.xfer(s[47-8*i-:8], i == 5 ? nb : 8, 1'b0, q);
    end
    hold_n = 1'b1;
    i_mst.close();
  endtask

  initial begin
    rows = '{'{8'h03, 3, 0, 0, 0, 24'h10, m4(8'h10)},
      '{8'h0b, 3, 1, 0, 0, 24'hfe, m4(8'hfe)},
      '{8'h3b, 3, 1, 1, 0, 24'h40, m4(8'h40)},
      '{8'h05, 0, 0, 0, 0, 24'h0, 32'h0},
      '{8'hab, 3, 0, 0, 0, 24'h0, {4{DID}}},
      '{8'h9f, 0, 0, 0, 0, 24'h0, JID},
      '{8'h03, 3, 0, 0, 1, 24'hff, m4(8'hff)}};
    repeat (20) @(negedge clk);
    reset_n = 1'b1;
    repeat (4) @(negedge clk);
    check("oe", {oe1_n, oe0_n}, 2'h3);
    check("status", status_out, 8'h00);
    for (int i = 0; i < 7; i++) begin
      i_mst.cpol = rows[i].m3;
      cmd(rows[i].op, rows[i].na, rows[i].nd, 4, rows[i].dual, rows[i].a, 0);
      check("read", r, rows[i].exp);
      i_mst.cpol = 1'b0;
    end
    i_mst.open();
    i_mst.xfer(8'h06, 5, 1'b0, q);
    i_mst.close();
    check("latch", status_out[1], 1'b0);
    cmd(8'h20, 3, 0, 0, 0, 24'h0, 0);
    check("refused", n_ops, 0);
    cmd(8'h06, 0, 0, 0, 0, 0, 0);
    check("latch", status_out[1], 1'b1);
    cmd(8'h04, 0, 0, 0, 0, 0, 0);
    check("latch", status_out[1], 1'b0);
    for (int i = 0; i < 5; i++) begin
      cmd(8'h06, 0, 0, 0, 0, 0, 0);
      n0 = n_ops;
      cmd(eop[i], i < 3 ? 3 : 0, 0, 0, 0, 24'h5a5a5a, 0);
      check("busy", status_out[0], 1'b1);
      check("start", n_ops - n0, 1);
      check("kind", kind_seen, ekind[i]);
      check("addr", addr_seen & emask[i], 24'h5a5a5a & emask[i]);
      wait_idle();
      check("done", status_out, 8'h00);
    end
    cmd(8'h06, 0, 0, 0, 0, 0, 0);
    cmd(8'h02, 3, 0, 2, 0, 24'h001200, 8'ha5);
    check("writes", n_wr, 2);
    check("data", pdata_seen, 8'ha5);
    check("kind", kind_seen, 2'h3);
    check("addr", addr_seen, 24'h001200);
    wait_idle();
    cmd(8'h06, 0, 0, 0, 0, 0, 0);
    n0 = n_ops;
    raw(48'h02_00_12_00_a5_a5, 3, 9);
    check("partial", n_ops - n0, 0);
    cmd(8'h04, 0, 0, 0, 0, 0, 0);
    for (int i = 0; i < 4; i++) begin
      wp_n = (i != 2);
      cmd(8'h06, 0, 0, 0, 0, 0, 0);
      cmd(8'h01, 0, 0, i == 0 ? 2 : 1, 0, 0, i == 1 ? 8'hff : 8'h00);
      wait_idle();
      check("sr", status_out[7:2], i == 1 || i == 2 ? 6'h2f : 6'h0);
    end
    raw(48'h03_00_00_ff_20_00, 8, 3);
    check("hold", q, 8'h20 ^ K);
    cmd(8'hb9, 0, 0, 0, 0, 0, 0);
    check("sleep", sleeping, 1'b1);
    cmd(8'h05, 0, 0, 1, 0, 0, 0);
    check("quiet", r[7:0], 8'hff);
    cmd(8'hab, 0, 0, 0, 0, 0, 0);
    check("wake", sleeping, 1'b0);
    results();
  end
endmodule
